// >>> pkg/ohb_params.svh
// Constants of the on-chip hardware barrier: unit counts, field positions,
// reset values and the command register map of the core agent.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef OHB_PARAMS_SVH
`define OHB_PARAMS_SVH

// ----------------------------------------------------------------------
// Barrier resources
// ----------------------------------------------------------------------
`define OHB_NUM_UNITS      12
`define OHB_NUM_WIDE       4
`define OHB_NUM_CORES      8
`define OHB_WIDE_BITS      8
`define OHB_ARR_RESET      8'h00
`define OHB_MASK_RESET     8'h00
`define OHB_LAST_RESET     1'b0

// ----------------------------------------------------------------------
// Setup word and binding word layouts
// ----------------------------------------------------------------------
`define OHB_SETUP_LAST_POS 16
`define OHB_SETUP_MASK_LSB 8
`define OHB_SETUP_ARR_LSB  0
`define OHB_BIND_VALID_POS 63
`define OHB_BIND_IDX_LSB   5

// ----------------------------------------------------------------------
// Core agent registers (AXI4-Lite byte addresses)
// ----------------------------------------------------------------------
`define OHB_REG_CMD        8'h00
`define OHB_REG_WLO        8'h04
`define OHB_REG_WHI        8'h08
`define OHB_REG_RLO        8'h0C
`define OHB_REG_RHI        8'h10
`define OHB_REG_STAT       8'h14
`define OHB_CMD_OP_LSB     0
`define OHB_CMD_IDX_LSB    4
`define OHB_CMD_CORE_LSB   8
`define OHB_STAT_BUSY_POS  0
`define OHB_STAT_DONE_POS  1
`define OHB_STAT_VAL_POS   2

`endif

// >>> pkg/ohb_pkg.sv
// Types shared by both ends of the on-chip hardware barrier.
// Assumes ohb_params.svh is on the include path.
`include "ohb_params.svh"

package ohb_pkg;

  // ----------------------------------------------------------------------
  // Link operations
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    OHB_OP_SETUP_WR, OHB_OP_SETUP_RD, OHB_OP_BIND_WR, OHB_OP_BIND_RD,
    OHB_OP_ARRIVE_WR, OHB_OP_LAST_RD, OHB_OP_BARRIER
  } ohb_op_t;

  typedef enum logic [1:0] {OHB_H_IDLE, OHB_H_REQ, OHB_H_WAIT, OHB_H_SLEEP} ohb_hstate_t;

  // ----------------------------------------------------------------------
  // Module state records
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] arrival;
    logic [7:0] mask;
    logic       last;
    logic       changed;
  } ohb_unit_state_t;

  typedef struct packed {
    logic [`OHB_NUM_CORES-1:0][`OHB_NUM_UNITS-1:0]      bind_valid;
    logic [`OHB_NUM_CORES-1:0][`OHB_NUM_UNITS-1:0][3:0] bind_idx;
    logic                                             rsp_valid;
    logic [63:0]                                      rsp_data;
  } ohb_dev_state_t;

  typedef struct packed {
    logic        aw_full;
    logic [7:0]  awaddr;
    logic        w_full;
    logic [31:0] wdata;
    logic        bvalid;
    logic        rvalid;
    logic [31:0] rdata;
    ohb_hstate_t fsm;
    ohb_op_t     op;
    logic [3:0]  index;
    logic [2:0]  core;
    logic [63:0] wreg;
    logic [63:0] rreg;
    logic        busy;
    logic        done;
    logic        woke;
    logic        bval;
    logic [1:0]  phase;
    logic        req_valid;
    ohb_op_t     req_op;
    logic [63:0] req_wdata;
  } ohb_host_state_t;

endpackage

// >>> pkg/ohb_link_if.sv
// Link between the barrier device and one core agent.
// Assumes the testbench instantiates it and joins both ends.
`timescale 1ns/100ps
`default_nettype none
`include "ohb_params.svh"

interface ohb_link_if;
  import ohb_pkg::*;

  // Request from a core
  logic                      req_valid;
  logic                      req_ready;
  ohb_op_t                   req_op;
  logic [2:0]                req_core;
  logic [3:0]                req_index;
  logic [63:0]               req_wdata;
  // Answer and wake-up
  logic                      rsp_valid;
  logic [63:0]               rsp_data;
  logic [`OHB_NUM_CORES-1:0] wake;

  modport dev  (input req_valid, req_op, req_core, req_index, req_wdata,
                output req_ready, rsp_valid, rsp_data, wake);
  modport core (output req_valid, req_op, req_core, req_index, req_wdata,
                input req_ready, rsp_valid, rsp_data, wake);
endinterface

`default_nettype wire

// >>> logic/ohb_sync_unit.sv
// One sync unit: arrival flags, participant mask and last sync value.
// Assumes writes arrive one at a time from the device end.
`timescale 1ns/100ps
`default_nettype none
`include "ohb_params.svh"

module ohb_sync_unit
  import ohb_pkg::*;
#(
  parameter int WIDTH = 8
)(
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Write requests
  input  wire logic       set_we,
  input  wire logic [16:0] set_data,
  input  wire logic       arr_we,
  input  wire logic [2:0] arr_core,
  input  wire logic       arr_val,
  // State
  output logic [7:0]      arrival,
  output logic [7:0]      mask,
  output logic            last,
  output logic            changed
);
  ohb_unit_state_t s, next_s;
  logic [7:0]      sel;

  // Update and re-evaluation share one edge, so no read sees a half state
  always_comb begin
    next_s = s;
    next_s.changed = 1'b0;
    sel = 8'h00;
    if (set_we) begin
      next_s.arrival = (WIDTH > 1) ? set_data[7:0] : {7'h00, set_data[0]};
      next_s.mask    = (WIDTH > 1) ? set_data[15:8] : 8'h00;
      next_s.last    = set_data[`OHB_SETUP_LAST_POS];
    end else if (arr_we) begin
      if (WIDTH > 1)
        next_s.arrival[arr_core] = arr_val;
      else
        next_s.arrival[0] = arr_val;
    end
    if (set_we || arr_we) begin
      if (WIDTH > 1) begin
        sel = next_s.arrival & next_s.mask;
        // Zero mask: no check, last value kept
        if (next_s.mask != 8'h00) begin
          if (sel == next_s.mask)
            next_s.last = 1'b1;
          else if (sel == 8'h00)
            next_s.last = 1'b0;
        end
      end else begin
        next_s.last = next_s.arrival[0];
      end
    end
    next_s.changed = (next_s.last != s.last);
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn)
      s <= '{arrival: `OHB_ARR_RESET, mask: `OHB_MASK_RESET, last: `OHB_LAST_RESET, changed: 1'b0};
    else
      s <= next_s;
  end

  assign arrival = s.arrival;
  assign mask    = s.mask;
  assign last    = s.last;
  assign changed = s.changed;
endmodule // ohb_sync_unit

`default_nettype wire

// >>> logic/ohb_barrier_dev.sv
// Device end of the on-chip hardware barrier: twelve sync units and the
// per-core window bindings, served over one request link.
// Assumes requests are on the aclk domain and answers are always accepted.
//
// Function
// - One barrier block shared by all cores.
// - Twelve independent sync units.
// - Four units: 8-bit arrival and mask.
// - Eight units: single arrival bit, no mask.
// - Each unit keeps a last sync value.
// - Sync when masked arrival bits all equal.
// - Common value copied into last sync value.
// - Last sync update atomic with arrival writes.
// - Last sync change wakes sleeping cores.
// - Thread writes inverse of last, then waits.
// - Twelve windows per core, one per unit.
// - Software uses windows, not unit state.
// - Accesses performed in program order.
// - Store-load fence after window store.
// - Full fence after side-effect register update.
// - Only cores on this chip take part.
// - Setup word: last 16, mask 15:8, arrival 7:0.
// - Re-check after setup; zero mask skips check.
// - Binding word: valid 63, unit 8:5.
// - Binding to unit twelve or above ignored.
`timescale 1ns/100ps
`default_nettype none
`include "ohb_params.svh"

module ohb_barrier_dev
  import ohb_pkg::*;
(
  // Clock and reset
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  // Core-side link
  ohb_link_if.dev                       link,
  // Observation of unit state
  output logic [`OHB_NUM_UNITS-1:0]     unit_last_sync,
  output logic [`OHB_NUM_UNITS-1:0]     unit_sync_event
);

  // ----------------------------------------------------------------------
  // State and decode
  // ----------------------------------------------------------------------
  ohb_dev_state_t                       s, next_s;
  logic                                 take;
  logic [3:0]                           req_i;
  logic [2:0]                           req_c;
  logic                                 idx_ok;
  logic                                 win_valid;
  logic [3:0]                           win_unit;
  logic [3:0]                           new_idx;
  logic [`OHB_NUM_UNITS-1:0][7:0]       u_arr;
  logic [`OHB_NUM_UNITS-1:0][7:0]       u_mask;
  logic [`OHB_NUM_UNITS-1:0]            u_last;
  logic [`OHB_NUM_UNITS-1:0]            u_changed;

  // Single request port: one access per edge keeps program order
  assign link.req_ready = 1'b1;
  assign take           = link.req_valid;

  // Core number is three bits: only this chip's cores can be named
  assign req_c  = link.req_core;
  assign req_i  = link.req_index;
  assign idx_ok = (req_i < 4'(`OHB_NUM_UNITS));

  // Window lookup for the calling core
  assign win_valid = idx_ok ? s.bind_valid[req_c][req_i] : 1'b0;
  assign win_unit  = idx_ok ? s.bind_idx[req_c][req_i] : 4'h0;

  // Unit named by a binding write
  assign new_idx = link.req_wdata[`OHB_BIND_IDX_LSB +: 4];

  // ----------------------------------------------------------------------
  // Sync units
  // ----------------------------------------------------------------------
  // Units below the wide count carry the full per-core vector
  for (genvar u = 0; u < `OHB_NUM_UNITS; u++) begin : g_unit
    ohb_sync_unit #(
      .WIDTH     ((u < `OHB_NUM_WIDE) ? `OHB_WIDE_BITS : 1)
    ) u_unit (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .set_we    (take && (link.req_op == OHB_OP_SETUP_WR) && (req_i == 4'(u))),
      .set_data  (link.req_wdata[16:0]),
      .arr_we    (take && (link.req_op == OHB_OP_ARRIVE_WR) && win_valid
                  && (win_unit == 4'(u))),
      .arr_core  (req_c),
      .arr_val   (link.req_wdata[0]),
      .arrival   (u_arr[u]),
      .mask      (u_mask[u]),
      .last      (u_last[u]),
      .changed   (u_changed[u])
    );
  end : g_unit

  // ----------------------------------------------------------------------
  // Request handling
  // ----------------------------------------------------------------------
  // Reads use pre-edge state; a read after a write sees its result
  always_comb begin
    next_s           = s;
    next_s.rsp_valid = take;
    next_s.rsp_data  = 64'h0;
    if (take) begin
      case (link.req_op)
        OHB_OP_SETUP_RD: begin
          // Single-bit units read zero in unused fields
          if (idx_ok)
            next_s.rsp_data = {47'h0, u_last[req_i], u_mask[req_i], u_arr[req_i]};
        end
        OHB_OP_BIND_WR: begin
          if (idx_ok) begin
            if (!link.req_wdata[`OHB_BIND_VALID_POS]) begin
              // Release: later arrival writes fall on no unit
              next_s.bind_valid[req_c][req_i] = 1'b0;
            end else if (new_idx < 4'(`OHB_NUM_UNITS)) begin
              next_s.bind_valid[req_c][req_i] = 1'b1;
              next_s.bind_idx[req_c][req_i]   = new_idx;
            end
          end
        end
        OHB_OP_BIND_RD: begin
          if (idx_ok) begin
            next_s.rsp_data[`OHB_BIND_VALID_POS]        = win_valid;
            next_s.rsp_data[`OHB_BIND_IDX_LSB +: 4]     = win_unit;
          end
        end
        OHB_OP_LAST_RD: begin
          // Unbound window reads zero
          if (win_valid)
            next_s.rsp_data = {63'h0, u_last[win_unit]};
        end
        default: begin
          // Arrival and setup writes answer with zero data
          next_s.rsp_data = 64'h0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // Answer one edge after the request
  assign link.rsp_valid = s.rsp_valid;
  assign link.rsp_data  = s.rsp_data;

  // Every core is woken; a core with nothing pending just re-reads and
  // sleeps again, which costs less than tracking who waits on what
  assign link.wake = {`OHB_NUM_CORES{|u_changed}};

  // Observation ports
  assign unit_last_sync  = u_last;
  assign unit_sync_event = u_changed;

endmodule // ohb_barrier_dev

`default_nettype wire

// >>> logic/ohb_core_agent.sv
// Core end: takes commands over AXI4-Lite and drives the barrier link,
// including a complete read-arrive-sleep barrier sequence.
// Assumes the device answers each request once and pulses wake.
`timescale 1ns/100ps
`default_nettype none
`include "ohb_params.svh"

module ohb_core_agent
  import ohb_pkg::*;
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Barrier link
  ohb_link_if.core         link
);
  ohb_host_state_t s, next_s;

  // Bus, command and link sequencing
  always_comb begin
    next_s = s;
    if (s.bvalid && s_axi_bready) next_s.bvalid = 1'b0;
    if (s.rvalid && s_axi_rready) next_s.rvalid = 1'b0;
    if (s_axi_awvalid && !s.aw_full) begin
      next_s.aw_full = 1'b1;
      next_s.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s.w_full) begin
      next_s.w_full = 1'b1;
      next_s.wdata  = s_axi_wdata;
    end
    // Partial strobes drop the write but still answer
    if (s.aw_full && s.w_full && !s.bvalid) begin
      next_s.aw_full = 1'b0;
      next_s.w_full  = 1'b0;
      next_s.bvalid  = 1'b1;
      if (s_axi_wstrb == 4'hF) begin
        case (s.awaddr)
          `OHB_REG_CMD: begin
            if (!s.busy) begin
              next_s.op        = ohb_op_t'(s.wdata[`OHB_CMD_OP_LSB +: 3]);
              next_s.index     = s.wdata[`OHB_CMD_IDX_LSB +: 4];
              next_s.core      = s.wdata[`OHB_CMD_CORE_LSB +: 3];
              next_s.busy      = 1'b1;
              next_s.done      = 1'b0;
              next_s.phase     = 2'd0;
              next_s.req_valid = 1'b1;
              next_s.req_op    = (next_s.op == OHB_OP_BARRIER) ? OHB_OP_LAST_RD : next_s.op;
              next_s.req_wdata = s.wreg;
              next_s.fsm       = OHB_H_REQ;
            end
          end
          `OHB_REG_WLO: next_s.wreg[31:0]  = s.wdata;
          `OHB_REG_WHI: next_s.wreg[63:32] = s.wdata;
          default: ;
        endcase
      end
    end
    if (s_axi_arvalid && !s.rvalid) begin
      next_s.rvalid = 1'b1;
      case (s_axi_araddr)
        `OHB_REG_CMD:  next_s.rdata = {21'h0, s.core, s.index, 1'b0, s.op};
        `OHB_REG_WLO:  next_s.rdata = s.wreg[31:0];
        `OHB_REG_WHI:  next_s.rdata = s.wreg[63:32];
        `OHB_REG_RLO:  next_s.rdata = s.rreg[31:0];
        `OHB_REG_RHI:  next_s.rdata = s.rreg[63:32];
        `OHB_REG_STAT: next_s.rdata = {29'h0, s.bval, s.done, s.busy};
        default:       next_s.rdata = 32'h0;
      endcase
    end
    // Link sequencing
    case (s.fsm)
      OHB_H_REQ: begin
        if (link.req_ready) begin
          next_s.req_valid = 1'b0;
          next_s.fsm       = OHB_H_WAIT;
        end
      end
      OHB_H_WAIT: begin
        // Each step waits for the previous answer: this is the fence
        if (link.rsp_valid) begin
          next_s.rreg = link.rsp_data;
          if (s.op != OHB_OP_BARRIER || (s.phase == 2'd2 && link.rsp_data[0] != s.bval)) begin
            next_s.busy = 1'b0;
            next_s.done = 1'b1;
            next_s.fsm  = OHB_H_IDLE;
          end else if (s.phase == 2'd0) begin
            next_s.bval      = link.rsp_data[0];
            next_s.req_valid = 1'b1;
            next_s.req_op    = OHB_OP_ARRIVE_WR;
            next_s.req_wdata = {63'h0, ~link.rsp_data[0]};
            next_s.phase     = 2'd1;
            next_s.fsm       = OHB_H_REQ;
          end else begin
            next_s.fsm = OHB_H_SLEEP;
          end
        end
      end
      OHB_H_SLEEP: begin
        if (s.woke) begin
          next_s.woke      = 1'b0;
          next_s.req_valid = 1'b1;
          next_s.req_op    = OHB_OP_LAST_RD;
          next_s.phase     = 2'd2;
          next_s.fsm       = OHB_H_REQ;
        end
      end
      default: ;
    endcase
    // A wake in the clearing cycle is kept
    if (link.wake[s.core]) next_s.woke = 1'b1;
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn)
      s <= '0;
    else
      s <= next_s;
  end

  // Outputs
  assign s_axi_awready  = !s.aw_full;
  assign s_axi_wready   = !s.w_full;
  assign s_axi_bvalid   = s.bvalid;
  assign s_axi_bresp    = 2'b00;
  assign s_axi_arready  = !s.rvalid;
  assign s_axi_rvalid   = s.rvalid;
  assign s_axi_rdata    = s.rdata;
  assign s_axi_rresp    = 2'b00;
  assign link.req_valid = s.req_valid;
  assign link.req_op    = s.req_op;
  assign link.req_core  = s.core;
  assign link.req_index = s.index;
  assign link.req_wdata = s.req_wdata;
endmodule // ohb_core_agent

`default_nettype wire

// >>> verification/ohb_link_monitor.sv
// Checker for the link between the barrier device and the core agent.
// Assumes the bench wires it to the signals of the link interface.
`timescale 1ns/100ps
`default_nettype none
`include "ohb_params.svh"

module ohb_link_monitor
  import ohb_pkg::*;
(
  // Clock and reset
  input wire logic                      aclk,
  input wire logic                      aresetn,
  // Link
  input wire logic                      req_valid,
  input wire logic                      req_ready,
  input wire ohb_op_t                   req_op,
  input wire logic [3:0]                req_index,
  input wire logic                      rsp_valid,
  input wire logic [63:0]               rsp_data,
  input wire logic [`OHB_NUM_CORES-1:0] wake
);
  // ------------------------------------------------------------
  // Request classes
  // ------------------------------------------------------------
  // Only writes may move unit state, so reads must never wake
  wire logic is_wr = req_op inside {OHB_OP_SETUP_WR, OHB_OP_BIND_WR, OHB_OP_ARRIVE_WR};

  default clocking mon_cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // ------------------------------------------------------------
  // Link properties
  // ------------------------------------------------------------
  rsp_follows_a: assert property (req_valid |=> rsp_valid)
    else $error("request not answered next cycle");
  rsp_cause_a: assert property (rsp_valid |-> $past(req_valid))
    else $error("answer without a request");
  take_all_a: assert property (req_valid |-> req_ready)
    else $error("request refused");
  wake_all_a: assert property (|wake |-> &wake)
    else $error("wake not sent to every core");
  wake_cause_a: assert property (|wake |-> $past(req_valid && is_wr) && rsp_valid)
    else $error("wake without a write");
  read_quiet_a: assert property (req_valid && !is_wr |=> wake == 8'h00)
    else $error("read changed a last value");
  wr_zero_a: assert property (req_valid && is_wr |=> rsp_data == 64'h0)
    else $error("write answered with data");
  far_unit_a: assert property (req_valid && req_index >= 4'hC |=> rsp_data == 64'h0 && wake == 8'h00)
    else $error("index above eleven had an effect");
  narrow_read_a: assert property (req_valid && req_op == OHB_OP_SETUP_RD && req_index inside {[4'h4:4'hB]}
    |=> rsp_data[63:17] == 47'h0 && rsp_data[15:1] == 15'h0)
    else $error("single-bit unit shows extra bits");
endmodule // ohb_link_monitor

`default_nettype wire

// >>> verification/onchip_hardware_barrier_tb.sv
// Bench for the barrier: core agent and device joined by the link,
// driven through the agent's AXI4-Lite port.
// Assumes design, package, interface and link monitor are compiled first.
`timescale 1ns/100ps
`default_nettype none
`include "ohb_params.svh"

module onchip_hardware_barrier_tb
  import ohb_pkg::*;
();
  typedef struct packed {
    ohb_op_t     op;
    logic [3:0]  idx;
    logic [2:0]  core;
    logic [63:0] wd;
    logic [63:0] mk;
    logic [63:0] ex;
  } ohb_row_t;
  localparam logic [63:0] all_bits = 64'hFFFF_FFFF_FFFF_FFFF;
  localparam logic [63:0] vbit     = 64'h8000_0000_0000_0000;
  localparam logic [63:0] zero     = 64'h0;
  // Ordinary cases: operation, index, core, write data, compare mask, answer
  localparam ohb_row_t rows [22] = '{
    '{OHB_OP_SETUP_WR, 4'h0, 3'h0, 64'h300, all_bits, zero},
    '{OHB_OP_BIND_WR, 4'h0, 3'h0, vbit, all_bits, zero},
    '{OHB_OP_BIND_RD, 4'h0, 3'h0, zero, vbit | 64'h1E0, vbit},
    '{OHB_OP_BIND_RD, 4'h0, 3'h3, zero, vbit, zero},
    '{OHB_OP_BIND_WR, 4'h1, 3'h1, vbit, all_bits, zero},
    '{OHB_OP_LAST_RD, 4'h0, 3'h0, zero, all_bits, zero},
    '{OHB_OP_ARRIVE_WR, 4'h0, 3'h0, 64'h1, all_bits, zero},
    '{OHB_OP_SETUP_RD, 4'h0, 3'h0, zero, all_bits, 64'h301},
    '{OHB_OP_ARRIVE_WR, 4'h1, 3'h1, 64'h1, all_bits, zero},
    '{OHB_OP_LAST_RD, 4'h1, 3'h1, zero, all_bits, 64'h1},
    '{OHB_OP_SETUP_RD, 4'h0, 3'h0, zero, all_bits, 64'h1_0303},
    '{OHB_OP_SETUP_WR, 4'h4, 3'h0, 64'h1_FFFF, all_bits, zero},
    '{OHB_OP_SETUP_RD, 4'h4, 3'h0, zero, all_bits, 64'h1_0001},
    '{OHB_OP_BIND_WR, 4'h2, 3'h2, vbit | 64'h180, all_bits, zero},
    '{OHB_OP_BIND_RD, 4'h2, 3'h2, zero, vbit, zero},
    '{OHB_OP_SETUP_WR, 4'h1, 3'h0, 64'h1_0000, all_bits, zero},
    '{OHB_OP_SETUP_RD, 4'h1, 3'h0, zero, all_bits, 64'h1_0000},
    '{OHB_OP_BIND_WR, 4'h3, 3'h0, vbit | 64'hA0, all_bits, zero},
    '{OHB_OP_ARRIVE_WR, 4'h3, 3'h0, 64'h1, all_bits, zero},
    '{OHB_OP_BIND_WR, 4'h3, 3'h0, zero, all_bits, zero},
    '{OHB_OP_ARRIVE_WR, 4'h3, 3'h0, zero, all_bits, zero},
    '{OHB_OP_SETUP_WR, 4'hC, 3'h0, 64'h1_FFFF, all_bits, zero}};

  // AXI side, idle at time zero
  logic        aclk          = 1'b0;
  logic        aresetn       = 1'b0;
  logic [7:0]  s_axi_awaddr  = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata   = 32'h0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_rdata;
  logic [11:0] unit_last_sync, unit_sync_event;
  int          mismatches    = 0;
  int          tests_run     = 0;
  int          cycles        = 0;
  int          sync_events   = 0;

  // ------------------------------------------------------------
  // Design, link and checker
  // ------------------------------------------------------------
  ohb_link_if ohb_link_if_inst ();
  ohb_barrier_dev ohb_barrier_dev_inst (.aclk(aclk), .aresetn(aresetn), .link(ohb_link_if_inst.dev),
    .unit_last_sync(unit_last_sync), .unit_sync_event(unit_sync_event));
  ohb_core_agent ohb_core_agent_inst (.aclk(aclk), .aresetn(aresetn), .link(ohb_link_if_inst.core),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
  ohb_link_monitor ohb_link_monitor_inst (.aclk(aclk), .aresetn(aresetn),
    .req_valid(ohb_link_if_inst.req_valid), .req_ready(ohb_link_if_inst.req_ready),
    .req_op(ohb_link_if_inst.req_op), .req_index(ohb_link_if_inst.req_index),
    .rsp_valid(ohb_link_if_inst.rsp_valid), .rsp_data(ohb_link_if_inst.rsp_data), .wake(ohb_link_if_inst.wake));

  // ------------------------------------------------------------
  // Clock, timeout and tasks
  // ------------------------------------------------------------
  always #4 aclk = ~aclk;

  // Hang ceiling, far above the several hundred cycles of the run; also counts unit six pulses
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (unit_sync_event[6]) sync_events++;
    if (cycles == 20000) begin
      mismatches++;
      close_out();
    end
  end

  // Address and data offered together, each released when taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    s_axi_rready <= 1'b0;
  endtask

  // One link operation through the agent; waits for done with busy low
  task automatic do_op(input ohb_op_t op, input logic [3:0] idx, input logic [2:0] core,
                       input logic [63:0] wd, output logic [63:0] rd);
    logic [31:0] st;
    axi_wr(`OHB_REG_WLO, wd[31:0]);
    axi_wr(`OHB_REG_WHI, wd[63:32]);
    axi_wr(`OHB_REG_CMD, {21'h0, core, idx, 1'b0, op});
    do axi_rd(`OHB_REG_STAT, st); while (st[1:0] !== 2'b10);
    axi_rd(`OHB_REG_RLO, rd[31:0]);
    axi_rd(`OHB_REG_RHI, rd[63:32]);
  endtask

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic close_out();
    $display("Checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    logic [63:0] got;
    logic [31:0] word;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(`OHB_REG_STAT, word);
    chk("status after reset", zero, {32'h0, word});
    foreach (rows[i]) begin
      do_op(rows[i].op, rows[i].idx, rows[i].core, rows[i].wd, got);
      chk($sformatf("row %0d", i), rows[i].ex, got & rows[i].mk);
      $display("Test row %0d done", i);
    end
    // Unbound window arrival must leave unit five synced at one
    do_op(OHB_OP_SETUP_RD, 4'h5, 3'h0, zero, got);
    chk("unit five after release", 64'h1_0001, got);
    axi_wr(8'h18, 32'hFFFF_FFFF);
    axi_rd(8'h18, word);
    chk("unmapped read", zero, {32'h0, word});
    $display("Test unmapped done");
    // Full barrier on single-bit unit six, flipping each way
    do_op(OHB_OP_BIND_WR, 4'h4, 3'h0, vbit | 64'hC0, got);
    for (int v = 1; v >= 0; v--) begin
      do_op(OHB_OP_BARRIER, 4'h4, 3'h0, zero, got);
      chk("barrier last read", 64'(v), got);
      chk("unit six last", 64'(v), {63'h0, unit_last_sync[6]});
    end
    chk("unit six sync events", 64'd2, 64'(sync_events));
    axi_rd(`OHB_REG_STAT, word);
    chk("status after barrier", 64'h6, {32'h0, word});
    axi_rd(`OHB_REG_CMD, word);
    chk("command readback", 64'h46, {32'h0, word});
    $display("Test barrier done");
    // Reset in mid-run clears units and bindings
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    do_op(OHB_OP_SETUP_RD, 4'h0, 3'h0, zero, got);
    chk("unit zero after reset", zero, got);
    do_op(OHB_OP_BIND_RD, 4'h0, 3'h0, zero, got);
    chk("binding after reset", zero, got & vbit);
    $display("Test second reset done");
    close_out();
  end
endmodule // onchip_hardware_barrier_tb

`default_nettype wire
